// ==== shared/pmes_pkg.sv ====
/*
 * pmes_pkg: constants for the performance-monitor event selection block:
 * register offsets, field positions, reset values and event class order.
 * Assumes a 12-bit byte address and a 32-bit register data path.
 */
package pmes_pkg;

    // bus geometry
    localparam int unsigned PMES_AW  = 12;
    localparam int unsigned PMES_DW  = 32;
    localparam int unsigned PMES_NEV = 7;   // event classes per accumulator
    localparam int unsigned PMES_CW  = 32;  // accumulator width

    // register byte offsets
    localparam logic [PMES_AW-1:0] PMES_SEL_OFS   = 12'h024;
    localparam logic [PMES_AW-1:0] PMES_ACC_A_OFS = 12'h028;
    localparam logic [PMES_AW-1:0] PMES_ACC_B_OFS = 12'h02C;

    // enable group positions inside the event-select register
    localparam int unsigned PMES_EN_A_LSB = 0;
    localparam int unsigned PMES_EN_B_LSB = 8;

    // event class order within each enable group
    localparam int unsigned PMES_EV_SHORT_PKT = 0;
    localparam int unsigned PMES_EV_FCS_ERR   = 1;
    localparam int unsigned PMES_EV_RX_ABORT  = 2;
    localparam int unsigned PMES_EV_LEN_ERR   = 3;
    localparam int unsigned PMES_EV_RX_GOOD   = 4;
    localparam int unsigned PMES_EV_TX_ABORT  = 5;
    localparam int unsigned PMES_EV_TX_GOOD   = 6;

    // writable bits of the event-select register, everything else reads 0
    localparam logic [PMES_DW-1:0] PMES_SEL_MASK = 32'h00007F7F;
    localparam logic [PMES_DW-1:0] PMES_SEL_RST  = 32'h00000000;
    localparam logic [PMES_CW-1:0] PMES_ACC_RST  = 32'h00000000;
    localparam logic [PMES_DW-1:0] PMES_UNMAPPED = 32'h00000000;

    // short-packet limits applied by the receive processor, in bits
    localparam int unsigned PMES_SHORT_BITS_CRC16 = 32;
    localparam int unsigned PMES_SHORT_BITS_CRC32 = 48;
    // abort code: this many ones or more in a row
    localparam int unsigned PMES_ABORT_ONES = 7;

endpackage : pmes_pkg

// ==== src/pmes_accum.sv ====
/*
 * pmes_accum: one saturating event accumulator fed by seven event class
 * pulses, each gated by its own enable bit.
 * Assumes event pulses are synchronous to ref_clk_i, at most one per class
 * per cycle; clr_i is a one-cycle strobe from the register decode.
 */
`timescale 1ns/1ps
module pmes_accum (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    input  wire logic [pmes_pkg::PMES_NEV-1:0] ev_i,
    input  wire logic [pmes_pkg::PMES_NEV-1:0] en_i,
    input  wire logic                          clr_i,
    output logic      [pmes_pkg::PMES_CW-1:0]  count_o
);
    import pmes_pkg::*;

    logic [PMES_NEV-1:0] hit;
    logic [2:0]          n_hit;
    logic [PMES_CW-1:0]  base;
    logic [PMES_CW:0]    sum;
    logic [PMES_CW-1:0]  next_count;

    // a disabled class never reaches the adder
    genvar g;
    generate
        for (g = 0; g < PMES_NEV; g++) begin : g_gate
            assign hit[g] = ev_i[g] & en_i[g];
        end
    endgenerate

    // every enabled class in the same cycle adds one, none is dropped
    always_comb begin
        n_hit = 3'h0;
        for (int i = 0; i < PMES_NEV; i++) begin
            n_hit = n_hit + {2'h0, hit[i]};
        end
    end

    // a clear that meets events restarts from the events, so none is lost
    assign base       = clr_i ? PMES_ACC_RST : count_o;
    assign sum        = {1'b0, base} + {30'h0, n_hit};
    // saturate rather than wrap: a wrapped count looks small and plausible
    assign next_count = sum[PMES_CW] ? {PMES_CW{1'b1}} : sum[PMES_CW-1:0];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_o <= PMES_ACC_RST;
        end else begin
            count_o <= next_count;
        end
    end

endmodule : pmes_accum

// ==== src/pmes_top.sv ====
/*
 * pmes_top: event selection register and two configurable performance
 * accumulators for the HDLC frame engine, behind a simple register port.
 * Assumes event pulses come from the receive and transmit HDLC processors,
 * synchronous to ref_clk_i, one cycle wide, and that the processors already
 * apply the short-packet, FCS, abort and length checks.
 */
// Our own choice: the plain strobed port.
// What this block does
// - two accumulators, class feeds picked by one event-select register
// - short received packet counts when its enable is high
// - received FCS mismatch counts when its enable is high
// - received abort, seven or more ones, counts when enabled
// - over-length or non-octet received packet counts when enabled
// - each error-free received packet counts when enabled
// - each transmitted abort counts when enabled
// - each error-free transmitted packet counts when enabled
// - a class with its enable low leaves that count untouched
// - accumulator one enables in bits 0..6, bit 7 unused
// - accumulator two enables in bits 8..14, bits 15..31 unused
// - all fourteen enables read/write and reset to zero
`timescale 1ns/1ps
module pmes_top (
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic [pmes_pkg::PMES_AW-1:0] addr_i,
    input  wire logic [pmes_pkg::PMES_DW-1:0] wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [pmes_pkg::PMES_DW-1:0] rdata_o,
    input  wire logic                         ev_short_pkt_i,
    input  wire logic                         ev_fcs_err_i,
    input  wire logic                         ev_rx_abort_i,
    input  wire logic                         ev_len_err_i,
    input  wire logic                         ev_rx_good_i,
    input  wire logic                         ev_tx_abort_i,
    input  wire logic                         ev_tx_good_i,
    output logic      [pmes_pkg::PMES_CW-1:0] count_a_o,
    output logic      [pmes_pkg::PMES_CW-1:0] count_b_o
);
    import pmes_pkg::*;

    logic [PMES_DW-1:0]  perf_event_select;
    logic [PMES_DW-1:0]  next_sel;
    logic [PMES_DW-1:0]  rd_val;
    logic [PMES_NEV-1:0] ev_vec;
    logic [PMES_NEV-1:0] en_a;
    logic [PMES_NEV-1:0] en_b;
    logic                sel_hit;
    logic                acc_a_hit;
    logic                acc_b_hit;
    logic                sel_wr;
    logic                clr_a;
    logic                clr_b;

    // address decode
    assign sel_hit   = (addr_i == PMES_SEL_OFS);
    assign acc_a_hit = (addr_i == PMES_ACC_A_OFS);
    assign acc_b_hit = (addr_i == PMES_ACC_B_OFS);
    assign sel_wr    = wr_i & sel_hit;
    // a write of any value to an accumulator restarts it from zero
    assign clr_a     = wr_i & acc_a_hit;
    assign clr_b     = wr_i & acc_b_hit;

    // unused bits are never stored, so they read back as zero
    assign next_sel = wdata_i & PMES_SEL_MASK;

    // event-select register, cleared so nothing counts after reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            perf_event_select <= PMES_SEL_RST;
        end else if (sel_wr) begin
            perf_event_select <= next_sel;
        end
    end

    // enable groups, one per accumulator, same class order in each
    assign en_a = perf_event_select[PMES_EN_A_LSB +: PMES_NEV];
    assign en_b = perf_event_select[PMES_EN_B_LSB +: PMES_NEV];

    // event classes packed in enable-bit order
    assign ev_vec[PMES_EV_SHORT_PKT] = ev_short_pkt_i;
    assign ev_vec[PMES_EV_FCS_ERR]   = ev_fcs_err_i;
    assign ev_vec[PMES_EV_RX_ABORT]  = ev_rx_abort_i;
    assign ev_vec[PMES_EV_LEN_ERR]   = ev_len_err_i;
    assign ev_vec[PMES_EV_RX_GOOD]   = ev_rx_good_i;
    assign ev_vec[PMES_EV_TX_ABORT]  = ev_tx_abort_i;
    assign ev_vec[PMES_EV_TX_GOOD]   = ev_tx_good_i;

    // both accumulators see the same events, so a shared class hits both
    pmes_accum u_acc_a (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ev_i      (ev_vec),
        .en_i      (en_a),
        .clr_i     (clr_a),
        .count_o   (count_a_o)
    );

    pmes_accum u_acc_b (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ev_i      (ev_vec),
        .en_i      (en_b),
        .clr_i     (clr_b),
        .count_o   (count_b_o)
    );

    // read select; unmapped addresses answer zero
    assign rd_val = sel_hit   ? perf_event_select :
                    acc_a_hit ? count_a_o :
                    acc_b_hit ? count_b_o :
                    PMES_UNMAPPED;

    // read data live only in the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= PMES_UNMAPPED;
        end else if (rd_i) begin
            rdata_o <= rd_val;
        end else begin
            rdata_o <= PMES_UNMAPPED;
        end
    end

    // checks of the register file and counting behaviour
    localparam logic [PMES_CW-1:0] CNT_NEAR_MAX = 32'hFFFFFF00;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_sel_reset_zero:
        assert property (@(posedge ref_clk_i) disable iff (1'b0)
            rst_i |=> (perf_event_select == PMES_SEL_RST))
        else $error("event select not zero after reset");

    a_sel_write_mask:
        assert property (sel_wr |=> (perf_event_select ==
                                     ($past(wdata_i) & PMES_SEL_MASK)))
        else $error("event select write not stored with mask");

    a_sel_unused_zero:
        assert property ((perf_event_select & ~PMES_SEL_MASK) == 32'h0)
        else $error("unused event select bits not zero");

    a_sel_hold_value:
        assert property (!sel_wr |=> $stable(perf_event_select))
        else $error("event select changed without a write");

    a_masked_a_hold:
        assert property (((ev_vec & en_a) == 7'h00) && !clr_a
                         |=> $stable(count_a_o))
        else $error("accumulator one moved on a disabled event");

    a_masked_b_hold:
        assert property (((ev_vec & en_b) == 7'h00) && !clr_b
                         |=> $stable(count_b_o))
        else $error("accumulator two moved on a disabled event");

    a_short_a_step:
        assert property ((ev_vec == 7'h01) && en_a[PMES_EV_SHORT_PKT] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("short packet not counted once in accumulator one");

    a_abort_b_step:
        assert property ((ev_vec == 7'h04) && en_b[PMES_EV_RX_ABORT] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("receive abort not counted once in accumulator two");

    // one class alone and enabled adds exactly one, in either accumulator
    a_short_b_step:
        assert property ((ev_vec == 7'h01) && en_b[PMES_EV_SHORT_PKT] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("short packet not counted once in accumulator two");

    a_fcs_a_step:
        assert property ((ev_vec == 7'h02) && en_a[PMES_EV_FCS_ERR] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("frame check error not counted in accumulator one");

    a_fcs_b_step:
        assert property ((ev_vec == 7'h02) && en_b[PMES_EV_FCS_ERR] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("frame check error not counted in accumulator two");

    a_abort_a_step:
        assert property ((ev_vec == 7'h04) && en_a[PMES_EV_RX_ABORT] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("receive abort not counted once in accumulator one");

    a_len_a_step:
        assert property ((ev_vec == 7'h08) && en_a[PMES_EV_LEN_ERR] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("length error not counted once in accumulator one");

    a_len_b_step:
        assert property ((ev_vec == 7'h08) && en_b[PMES_EV_LEN_ERR] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("length error not counted once in accumulator two");

    a_rx_good_a:
        assert property ((ev_vec == 7'h10) && en_a[PMES_EV_RX_GOOD] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("good receive not counted once in accumulator one");

    a_rx_good_b:
        assert property ((ev_vec == 7'h10) && en_b[PMES_EV_RX_GOOD] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("good receive not counted once in accumulator two");

    a_tx_abort_a:
        assert property ((ev_vec == 7'h20) && en_a[PMES_EV_TX_ABORT] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("transmit abort not counted in accumulator one");

    a_tx_abort_b:
        assert property ((ev_vec == 7'h20) && en_b[PMES_EV_TX_ABORT] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("transmit abort not counted in accumulator two");

    a_tx_good_a:
        assert property ((ev_vec == 7'h40) && en_a[PMES_EV_TX_GOOD] &&
                         !clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) + 32'h1)
        else $error("good transmit not counted once in accumulator one");

    a_tx_good_b:
        assert property ((ev_vec == 7'h40) && en_b[PMES_EV_TX_GOOD] &&
                         !clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) + 32'h1)
        else $error("good transmit not counted once in accumulator two");

    // every class enabled in both places must bump both counts by seven
    a_shared_both:
        assert property ((ev_vec == 7'h7F) && (en_a == 7'h7F) &&
                         (en_b == 7'h7F) && !clr_a && !clr_b &&
                         (count_a_o < CNT_NEAR_MAX) &&
                         (count_b_o < CNT_NEAR_MAX)
                         |=> (count_a_o == $past(count_a_o) + 32'h7) &&
                             (count_b_o == $past(count_b_o) + 32'h7))
        else $error("shared events not counted in both accumulators");

    a_all_counted_a:
        assert property (!clr_a && (count_a_o < CNT_NEAR_MAX)
                         |=> count_a_o == $past(count_a_o) +
                             32'($countones($past(ev_vec & en_a))))
        else $error("simultaneous events lost in accumulator one");

    a_all_counted_b:
        assert property (!clr_b && (count_b_o < CNT_NEAR_MAX)
                         |=> count_b_o == $past(count_b_o) +
                             32'($countones($past(ev_vec & en_b))))
        else $error("simultaneous events lost in accumulator two");

    a_clear_keeps_a:
        assert property (clr_a |=> count_a_o ==
                         32'($countones($past(ev_vec & en_a))))
        else $error("clear of accumulator one dropped same-cycle events");

    a_clear_keeps_b:
        assert property (clr_b |=> count_b_o ==
                         32'($countones($past(ev_vec & en_b))))
        else $error("clear of accumulator two dropped same-cycle events");

    // read answers stand one cycle only, unless another read follows
    a_read_count_a:
        assert property (rd_i && acc_a_hit
                         |=> rdata_o == $past(count_a_o) ##1
                             ($past(rd_i) || rdata_o == PMES_UNMAPPED))
        else $error("accumulator one read data wrong");

    a_read_count_b:
        assert property (rd_i && acc_b_hit
                         |=> rdata_o == $past(count_b_o) ##1
                             ($past(rd_i) || rdata_o == PMES_UNMAPPED))
        else $error("accumulator two read data wrong");

    a_read_sel_value:
        assert property (rd_i && sel_hit
                         |=> rdata_o == $past(perf_event_select))
        else $error("event select read data wrong");

    a_read_unmapped:
        assert property (rd_i && !sel_hit && !acc_a_hit && !acc_b_hit
                         |=> rdata_o == PMES_UNMAPPED)
        else $error("unmapped read did not answer zero");

    a_count_reset_zero:
        assert property (@(posedge ref_clk_i) disable iff (1'b0)
            rst_i |=> (count_a_o == PMES_ACC_RST) &&
                      (count_b_o == PMES_ACC_RST) &&
                      (rdata_o == PMES_UNMAPPED))
        else $error("counts or read data not zero after reset");

    a_read_sel_idle:
        assert property (!rd_i |=> rdata_o == PMES_UNMAPPED)
        else $error("read data not zero outside the read answer cycle");

    // main scenarios
    c_shared_event: cover property (
        ((ev_vec & en_a & en_b) != 7'h00) ##1 1'b1);
    c_many_at_once: cover property ($countones(ev_vec & en_a) > 2);
    c_clear_with_event: cover property (clr_b && ((ev_vec & en_b) != 7'h00));
    c_read_after_write: cover property (sel_wr ##1 (rd_i && sel_hit));

endmodule : pmes_top

// ==== verif/tb.sv ====
/*
 * tb: self-checking bench for pmes_top. It writes and reads the
 * event-select and accumulator registers, pulses the event inputs and
 * compares both counts against values worked out here.
 * Assumes the register port answers reads one cycle after the strobe and
 * that a write to an accumulator offset clears it.
 */
`timescale 1ns/1ps
module tb;
    import pmes_pkg::*;

    logic                ref_clk_i;
    logic                rst_i;
    logic                wr_i;
    logic                rd_i;
    logic [PMES_AW-1:0]  addr_i;
    logic [PMES_DW-1:0]  wdata_i;
    logic [PMES_DW-1:0]  rdata_o;
    logic [PMES_DW-1:0]  sel;
    logic [PMES_CW-1:0]  count_a_o;
    logic [PMES_CW-1:0]  count_b_o;
    logic [PMES_CW-1:0]  exp_a;
    logic [PMES_CW-1:0]  exp_b;
    logic [PMES_NEV-1:0] ev;
    logic [PMES_NEV-1:0] one;
    int                  error_cnt;
    int                  total_checks;

    pmes_top u_dut (
        .ref_clk_i      (ref_clk_i),
        .rst_i          (rst_i),
        .addr_i         (addr_i),
        .wdata_i        (wdata_i),
        .wr_i           (wr_i),
        .rd_i           (rd_i),
        .rdata_o        (rdata_o),
        .ev_short_pkt_i (ev[PMES_EV_SHORT_PKT]),
        .ev_fcs_err_i   (ev[PMES_EV_FCS_ERR]),
        .ev_rx_abort_i  (ev[PMES_EV_RX_ABORT]),
        .ev_len_err_i   (ev[PMES_EV_LEN_ERR]),
        .ev_rx_good_i   (ev[PMES_EV_RX_GOOD]),
        .ev_tx_abort_i  (ev[PMES_EV_TX_ABORT]),
        .ev_tx_good_i   (ev[PMES_EV_TX_GOOD]),
        .count_a_o      (count_a_o),
        .count_b_o      (count_b_o)
    );

    // 200 MHz clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    // one comparison of a 32-bit result
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %08h exp %08h", $time, got, exp);
        end
    endtask : cmp

    // verdict and end of run
    task stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // one-cycle write; the bench mirrors which bits are expected to stick
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        if (a == PMES_SEL_OFS) sel = d & PMES_SEL_MASK;
        if (a == PMES_ACC_A_OFS) exp_a = PMES_ACC_RST;
        if (a == PMES_ACC_B_OFS) exp_b = PMES_ACC_RST;
    endtask : wr

    // one-cycle read; data looked at only in the cycle after the strobe
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        cmp(rdata_o, e);
    endtask : rd

    // hold pattern p on the event inputs for n cycles, then idle one
    task pulse(input logic [6:0] p, input int n);
        @(posedge ref_clk_i);
        ev <= p;
        repeat (n) @(posedge ref_clk_i);
        ev <= '0;
        exp_a = exp_a +
                32'(n * $countones(p & sel[PMES_EN_A_LSB +: PMES_NEV]));
        exp_b = exp_b +
                32'(n * $countones(p & sel[PMES_EN_B_LSB +: PMES_NEV]));
        @(posedge ref_clk_i);
        #1;
    endtask : pulse

    // clear an accumulator in the same cycle as events p; the events win
    task clr_ev(input logic [11:0] a, input logic [6:0] p);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= '0;
        ev      <= p;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        ev      <= '0;
        if (a == PMES_ACC_A_OFS) exp_a = PMES_ACC_RST;
        if (a == PMES_ACC_B_OFS) exp_b = PMES_ACC_RST;
        exp_a = exp_a + 32'($countones(p & sel[PMES_EN_A_LSB +: PMES_NEV]));
        exp_b = exp_b + 32'($countones(p & sel[PMES_EN_B_LSB +: PMES_NEV]));
        @(posedge ref_clk_i);
        #1;
    endtask : clr_ev

    // watchdog so a stuck run still reaches the verdict
    initial begin
        #500000;
        error_cnt++;
        stop_test();
    end

    initial begin
        ref_clk_i = 1'b0;
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        ev = '0;
        sel = '0;
        exp_a = '0;
        exp_b = '0;
        error_cnt = 0;
        total_checks = 0;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // after reset nothing is enabled, so no event may count
        rd(PMES_SEL_OFS, 32'h00000000);
        pulse(7'h7F, 1);
        cmp(count_a_o, 32'h00000000);
        cmp(count_b_o, 32'h00000000);
        // field layout: only bits 0..6 and 8..14 stick
        wr(PMES_SEL_OFS, 32'hFFFFFFFF);
        rd(PMES_SEL_OFS, 32'h00007F7F);
        @(posedge ref_clk_i);
        #1;
        cmp(rdata_o, 32'h00000000);
        wr(PMES_SEL_OFS, 32'hFFFFA5A5);
        rd(PMES_SEL_OFS, 32'h00002525);
        wr(PMES_SEL_OFS, 32'h00000000);
        // an unmapped write must not disturb the select register
        wr(12'h030, 32'hFFFFFFFF);
        rd(12'h030, 32'h00000000);
        rd(PMES_SEL_OFS, 32'h00000000);
        // each class alone on A, every other class on B, all pulsing
        for (int i = 0; i < 7; i++) begin
            one = 7'(1 << i);
            wr(PMES_ACC_A_OFS, 32'h00000000);
            wr(PMES_ACC_B_OFS, 32'h00000000);
            wr(PMES_SEL_OFS, {17'h00000, ~one, 1'b0, one});
            pulse(7'h7F, 1);
            cmp(count_a_o, exp_a);
            cmp(count_b_o, exp_b);
            pulse(one, 1);
            // the next class over is enabled on B only
            pulse(7'(1 << ((i + 1) % 7)), 1);
            rd(PMES_ACC_A_OFS, exp_a);
            rd(PMES_ACC_B_OFS, exp_b);
        end
        // shared enables, all classes on consecutive cycles
        wr(PMES_ACC_A_OFS, 32'h00000000);
        wr(PMES_ACC_B_OFS, 32'h00000000);
        wr(PMES_SEL_OFS, 32'h00007F7F);
        pulse(7'h7F, 3);
        cmp(count_a_o, exp_a);
        cmp(count_b_o, exp_b);
        rd(PMES_ACC_B_OFS, 32'h00000015);
        // a clear meeting two enabled events keeps them; A counts on
        clr_ev(PMES_ACC_B_OFS, 7'h05);
        cmp(count_a_o, exp_a);
        cmp(count_b_o, 32'h00000002);
        // a reset in mid-run clears the enables and both counts
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        sel = PMES_SEL_RST;
        exp_a = PMES_ACC_RST;
        exp_b = PMES_ACC_RST;
        rd(PMES_SEL_OFS, 32'h00000000);
        pulse(7'h7F, 1);
        cmp(count_a_o, 32'h00000000);
        cmp(count_b_o, 32'h00000000);
        stop_test();
    end

endmodule : tb
